/* hw/sfs_pkg.sv */
package sfs_pkg;
   localparam int CLK_MHZ    = 40;
   localparam int FRAME_BITS = 32;
   localparam int CMD_MSB    = 31;
   localparam int CMD_LSB    = 28;
   localparam int RW_BIT     = 27;
   localparam int DATA_MSB   = 26;
   localparam int DATA_LSB   = 1;
   localparam int DATA_W     = 26;
   localparam int PAYLOAD_W  = 31;
   localparam int CNT_W      = 5;
   localparam logic [3:0] LAST_CMD = 4'hd;
   localparam logic [FRAME_BITS-1:0] ZERO_FRAME = 32'h0;
   localparam logic RW_READ_ONLY = 1'h1;
   localparam int FIFO_DEPTH = 32;
   localparam int SEL_DEGLITCH_NS = 25;
   localparam logic [1:0] DGL_CYC = 2'((SEL_DEGLITCH_NS * CLK_MHZ + 999) / 1000);
   localparam int CC_W        = 23;
   localparam int CC_TIME_US  = 70000;
   localparam int CC_INIT_US  = 137500;
   localparam int CC_CYC      = CC_TIME_US * CLK_MHZ;
   localparam int CC_INIT_CYC = CC_INIT_US * CLK_MHZ;
   localparam int SCK_HALF_NS = 100;
   localparam int LEAD_NS     = 600;
   localparam int TRAIL_NS    = 100;
   localparam int GAP_NS      = 400;
   localparam logic [CNT_W-1:0] HALF_CYC  = CNT_W'((SCK_HALF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] LEAD_CYC  = CNT_W'((LEAD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] TRAIL_CYC = CNT_W'((TRAIL_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] GAP_CYC   = CNT_W'((GAP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W:0]   LAST_BIT  = 6'h1f;

   function automatic logic sfs_par_bit(input logic [PAYLOAD_W-1:0] p);
      return ~(^p);
   endfunction

   function automatic logic sfs_frame_ok(input logic [FRAME_BITS-1:0] f);
      return ^f;
   endfunction
endpackage

/* hw/sfs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfs_link_if;
   logic ncs;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   modport dev
   (
      input  ncs,
      input  sck,
      input  sdi,
      output sdo,
      output sdo_oe
   );
   modport host
   (
      output ncs,
      output sck,
      output sdi,
      input  sdo,
      input  sdo_oe
   );
endinterface
`default_nettype wire

/* hw/sfs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_fifo
   import sfs_pkg::*;
#(
   parameter int WIDTH = PAYLOAD_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      cnt;
   logic [AW-1:0]    next_wptr;
   logic [AW-1:0]    next_rptr;
   logic [AW:0]      next_cnt;
   logic             push;
   logic             pop;

   always_comb
   begin
      in_ready  = (cnt != (AW+1)'(DEPTH));
      out_valid = (cnt != '0);
      out_data  = mem[rptr];
      push      = in_valid & in_ready;
      pop       = out_valid & out_ready;
      next_wptr = push ? AW'(wptr + 1'b1) : wptr;
      next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
      next_cnt  = cnt;
      if (push & ~pop)
      begin
         next_cnt = (AW+1)'(cnt + 1'b1);
      end
      else if (pop & ~push)
      begin
         next_cnt = (AW+1)'(cnt - 1'b1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wptr <= '0;
         rptr <= '0;
         cnt  <= '0;
      end
      else
      begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         cnt  <= next_cnt;
      end
   end

   // Storage needs no reset; empty flag guards stale words
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

/* hw/sfs_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_dev
   import sfs_pkg::*;
#(
   parameter int CC_LIMIT      = CC_CYC,
   parameter int CC_INIT_LIMIT = CC_INIT_CYC
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   sfs_link_if.dev                    link,
   input  wire logic                  disable_pin_active_high,
   input  wire logic                  disable_pin_active_low,
   output logic                       rx_valid,
   input  wire logic                  rx_ready,
   output logic      [PAYLOAD_W-1:0]  rx_data,
   output logic      [3:0]            rx_cmd,
   input  wire logic [DATA_W-1:0]     rsp_data,
   output logic                       cc_fault
);
   typedef enum logic [3:0]
   {
      CC_BOOT = 4'h1,
      CC_WAIT = 4'h2,
      CC_INIT = 4'h4,
      CC_RUN  = 4'h8
   } sfs_cc_t;

   // Select filter and edge detection
   logic       ncs_f;
   logic       ncs_fq;
   logic       sck_q;
   logic [1:0] dg_cnt;
   logic       next_ncs_f;
   logic [1:0] next_dg_cnt;
   logic       sel_fall;
   logic       sel_rise;
   logic       sck_rise;
   logic       sck_fall;

   always_comb
   begin
      next_ncs_f  = ncs_f;
      next_dg_cnt = '0;
      if (link.ncs != ncs_f)
      begin
         next_dg_cnt = 2'(dg_cnt + 1'b1);
         if (dg_cnt == DGL_CYC)
         begin
            next_ncs_f  = link.ncs;
            next_dg_cnt = '0;
         end
      end
      sel_fall = ncs_fq & ~ncs_f;
      sel_rise = ncs_f & ~ncs_fq;
      // Sampling at 40 MHz leaves four samples per half period at 5 MHz
      sck_rise = ~ncs_f & link.sck & ~sck_q;
      sck_fall = ~ncs_f & ~link.sck & sck_q;
   end

   // Reset forces idle select, so link activity is ignored meanwhile
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ncs_f  <= 1'b1;
         ncs_fq <= 1'b1;
         sck_q  <= 1'b0;
         dg_cnt <= '0;
      end
      else
      begin
         ncs_f  <= next_ncs_f;
         ncs_fq <= ncs_f;
         sck_q  <= link.sck;
         dg_cnt <= next_dg_cnt;
      end
   end

   // Frame shifter and reply
   logic [FRAME_BITS-1:0] sr;
   logic [FRAME_BITS-1:0] reply;
   logic [CNT_W-1:0]      bit_cnt;
   logic                  any_clk;
   logic                  sdo_q;
   logic                  oe_q;
   logic                  build;
   logic [3:0]            cmd_q;
   logic                  rw_q;
   logic                  flt_q;
   logic                  next_flt;
   logic [FRAME_BITS-1:0] next_sr;
   logic [FRAME_BITS-1:0] next_reply;
   logic [CNT_W-1:0]      next_bit_cnt;
   logic                  next_any_clk;
   logic                  next_sdo;
   logic                  next_oe;
   logic                  next_build;
   logic [3:0]            next_cmd;
   logic                  next_rw;
   logic                  frame_good;
   logic                  push;
   logic                  push_ready;
   logic                  valid_comm;
   logic [PAYLOAD_W-1:0]  body;

   always_comb
   begin
      next_sr      = sr;
      next_reply   = reply;
      next_bit_cnt = bit_cnt;
      next_any_clk = any_clk;
      next_sdo     = sdo_q;
      next_oe      = oe_q;
      next_build   = 1'b0;
      next_cmd     = cmd_q;
      next_rw      = rw_q;
      next_flt     = flt_q;
      push         = 1'b0;
      valid_comm   = 1'b0;
      body         = '0;
      frame_good   = (bit_cnt == '0)
                     & sfs_frame_ok(sr)
                     & (sr[CMD_MSB:CMD_LSB] <= LAST_CMD)
                     & push_ready;
      if (sel_fall)
      begin
         next_sr      = reply;
         next_sdo     = reply[FRAME_BITS-1];
         next_oe      = 1'b1;
         next_bit_cnt = '0;
         next_any_clk = 1'b0;
      end
      else if (sel_rise)
      begin
         next_oe = 1'b0;
         if (any_clk)
         begin
            next_reply = ZERO_FRAME;
            if (frame_good)
            begin
               push       = 1'b1;
               valid_comm = 1'b1;
               next_build = 1'b1;
               next_cmd   = sr[CMD_MSB:CMD_LSB];
               next_rw    = sr[RW_BIT];
               // The access clears the fault, so keep its state for the reply
               next_flt   = cc_fault;
            end
         end
      end
      else
      begin
         if (sck_rise)
         begin
            next_sdo = sr[FRAME_BITS-1];
         end
         if (sck_fall)
         begin
            // Received bits enter behind the reply so a chain passes frames on
            next_sr      = {sr[FRAME_BITS-2:0], link.sdi};
            next_bit_cnt = CNT_W'(bit_cnt + 1'b1);
            next_any_clk = 1'b1;
         end
      end
      if (build)
      begin
         // Payload arrives one cycle after the command is shown; the gap covers it
         body = {cmd_q, rw_q, rsp_data[DATA_W-1:1], flt_q};
         next_reply = {body, sfs_par_bit(body)};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sr      <= ZERO_FRAME;
         reply   <= ZERO_FRAME;
         bit_cnt <= '0;
         any_clk <= 1'b0;
         sdo_q   <= 1'b0;
         oe_q    <= 1'b0;
         build   <= 1'b0;
         cmd_q   <= '0;
         rw_q    <= RW_READ_ONLY;
         flt_q   <= 1'b0;
      end
      else
      begin
         sr      <= next_sr;
         reply   <= next_reply;
         bit_cnt <= next_bit_cnt;
         any_clk <= next_any_clk;
         sdo_q   <= next_sdo;
         oe_q    <= next_oe;
         build   <= next_build;
         cmd_q   <= next_cmd;
         rw_q    <= next_rw;
         flt_q   <= next_flt;
      end
   end

   assign link.sdo    = sdo_q;
   assign link.sdo_oe = oe_q;
   assign rx_cmd      = cmd_q;

   // A full queue refuses the frame: it is answered with zeros instead
   sfs_fifo #(
      .WIDTH (PAYLOAD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   (sr[FRAME_BITS-1:1]),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // Communication check
   sfs_cc_t         cc_st;
   sfs_cc_t         next_cc_st;
   logic [CC_W-1:0] cc_cnt;
   logic [CC_W-1:0] next_cc_cnt;
   logic [CC_W-1:0] cc_lim;
   logic            next_fault;
   logic            released;

   always_comb
   begin
      released    = ~disable_pin_active_high & disable_pin_active_low;
      next_cc_st  = cc_st;
      next_cc_cnt = cc_cnt;
      next_fault  = cc_fault;
      cc_lim      = (cc_st == CC_INIT) ? CC_W'(CC_INIT_LIMIT - 1) : CC_W'(CC_LIMIT - 1);
      case (cc_st)
         CC_BOOT:
         begin
            next_cc_cnt = '0;
            next_cc_st  = released ? CC_INIT : CC_WAIT;
         end
         CC_WAIT:
         begin
            next_cc_cnt = '0;
            if (released)
            begin
               next_cc_st = CC_RUN;
            end
         end
         CC_INIT, CC_RUN:
         begin
            if (!released)
            begin
               next_cc_st  = CC_WAIT;
               next_cc_cnt = '0;
            end
            else if (valid_comm)
            begin
               next_cc_st  = CC_RUN;
               next_cc_cnt = '0;
               next_fault  = 1'b0;
            end
            else if (cc_cnt == cc_lim)
            begin
               next_cc_st  = CC_RUN;
               next_cc_cnt = '0;
               next_fault  = 1'b1;
            end
            else
            begin
               next_cc_cnt = CC_W'(cc_cnt + 1'b1);
            end
         end
         default:
         begin
            next_cc_st  = CC_BOOT;
            next_cc_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cc_st    <= CC_BOOT;
         cc_cnt   <= '0;
         cc_fault <= 1'b0;
      end
      else
      begin
         cc_st    <= next_cc_st;
         cc_cnt   <= next_cc_cnt;
         cc_fault <= next_fault;
      end
   end
endmodule
`default_nettype wire

/* hw/sfs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_host
   import sfs_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   sfs_link_if.host                   link,
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire logic [3:0]            req_cmd,
   input  wire logic                  req_rw,
   input  wire logic [DATA_W-1:0]     req_data,
   output logic                       rsp_valid,
   output logic      [FRAME_BITS-1:0] rsp_frame,
   output logic                       rsp_par_ok
);
   typedef enum logic [5:0]
   {
      H_IDLE  = 6'h01,
      H_LEAD  = 6'h02,
      H_HIGH  = 6'h04,
      H_LOW   = 6'h08,
      H_TRAIL = 6'h10,
      H_GAP   = 6'h20
   } sfs_host_st_t;

   sfs_host_st_t          st;
   sfs_host_st_t          next_st;
   logic [CNT_W-1:0]      tmr;
   logic [CNT_W-1:0]      next_tmr;
   logic [CNT_W:0]        bits;
   logic [CNT_W:0]        next_bits;
   logic [FRAME_BITS-1:0] tx;
   logic [FRAME_BITS-1:0] next_tx;
   logic [FRAME_BITS-1:0] next_rx;
   logic                  ncs;
   logic                  sck;
   logic                  sdi;
   logic                  next_ncs;
   logic                  next_sck;
   logic                  next_sdi;
   logic                  next_rsp_valid;
   logic                  next_par_ok;
   logic                  tmr_done;
   logic [PAYLOAD_W-1:0]  body;

   always_comb
   begin
      next_st        = st;
      next_tmr       = CNT_W'(tmr + 1'b1);
      next_bits      = bits;
      next_tx        = tx;
      next_rx        = rsp_frame;
      next_ncs       = ncs;
      next_sck       = sck;
      next_sdi       = sdi;
      next_rsp_valid = 1'b0;
      next_par_ok    = rsp_par_ok;
      body           = {req_cmd, req_rw, req_data};
      tmr_done       = 1'b0;
      case (st)
         H_IDLE:
         begin
            next_tmr = '0;
            // Ready is low in the first cycle after reset, so nothing is taken then
            if (req_valid && req_ready)
            begin
               next_tx   = {body, sfs_par_bit(body)};
               next_ncs  = 1'b0;
               next_bits = '0;
               next_st   = H_LEAD;
            end
         end
         H_LEAD:
         begin
            tmr_done = (tmr == CNT_W'(LEAD_CYC - 1'b1));
         end
         H_HIGH:
         begin
            tmr_done = (tmr == CNT_W'(HALF_CYC - 1'b1));
         end
         H_LOW:
         begin
            tmr_done = (tmr == CNT_W'(HALF_CYC - 1'b1));
         end
         H_TRAIL:
         begin
            tmr_done = (tmr == CNT_W'(TRAIL_CYC - 1'b1));
         end
         H_GAP:
         begin
            tmr_done = (tmr == CNT_W'(GAP_CYC - 1'b1));
         end
         default:
         begin
            next_st = H_IDLE;
         end
      endcase
      if (tmr_done)
      begin
         next_tmr = '0;
         case (st)
            H_LEAD, H_LOW:
            begin
               if (st == H_LOW && bits == LAST_BIT)
               begin
                  next_st = H_TRAIL;
               end
               else
               begin
                  // Mode 1: data moves on the rising edge
                  next_sck = 1'b1;
                  next_sdi = tx[FRAME_BITS-1];
                  next_st  = H_HIGH;
                  if (st == H_LOW)
                  begin
                     next_bits = (CNT_W+1)'(bits + 1'b1);
                  end
               end
            end
            H_HIGH:
            begin
               next_sck = 1'b0;
               next_tx  = {tx[FRAME_BITS-2:0], 1'b0};
               next_rx  = {rsp_frame[FRAME_BITS-2:0], link.sdo & link.sdo_oe};
               next_st  = H_LOW;
            end
            H_TRAIL:
            begin
               next_ncs = 1'b1;
               next_st  = H_GAP;
            end
            H_GAP:
            begin
               // Select stays high for the full gap before the next frame
               next_rsp_valid = 1'b1;
               next_par_ok    = sfs_frame_ok(rsp_frame);
               next_st        = H_IDLE;
            end
            default:
            begin
               next_st = H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st         <= H_IDLE;
         tmr        <= '0;
         bits       <= '0;
         tx         <= ZERO_FRAME;
         rsp_frame  <= ZERO_FRAME;
         ncs        <= 1'b1;
         sck        <= 1'b0;
         sdi        <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_par_ok <= 1'b0;
         req_ready  <= 1'b0;
      end
      else
      begin
         st         <= next_st;
         tmr        <= next_tmr;
         bits       <= next_bits;
         tx         <= next_tx;
         rsp_frame  <= next_rx;
         ncs        <= next_ncs;
         sck        <= next_sck;
         sdi        <= next_sdi;
         rsp_valid  <= next_rsp_valid;
         rsp_par_ok <= next_par_ok;
         req_ready  <= (next_st == H_IDLE);
      end
   end

   assign link.ncs = ncs;
   assign link.sck = sck;
   assign link.sdi = sdi;
endmodule
`default_nettype wire

/* tb/sfs_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_link_properties
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ncs,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic [4:0] hi_cnt;
   logic [4:0] next_hi_cnt;
   logic [6:0] bit_cnt;
   logic [6:0] next_bit_cnt;
   logic       sck_q;
   logic       next_sck_q;

   default clocking cb @(posedge clk_sys);
   endclocking

   // Saturates so a long idle never wraps into a false short gap
   always_comb
   begin
      next_hi_cnt  = ncs ? ((hi_cnt == 5'h1f) ? hi_cnt : hi_cnt + 5'h1) : 5'h0;
      next_bit_cnt = ncs ? 7'h0 : bit_cnt + {6'h0, sck & ~sck_q};
      next_sck_q   = sck;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi_cnt  <= 5'h1f;
         bit_cnt <= 7'h0;
         sck_q   <= 1'b0;
      end
      else
      begin
         hi_cnt  <= next_hi_cnt;
         bit_cnt <= next_bit_cnt;
         sck_q   <= next_sck_q;
      end
   end

   a_reset_quiet: assert property (!rst_n |-> !sdo_oe)
      else $error("serial output driven during reset");
   a_sck_idle: assert property (disable iff (!rst_n) ncs |-> !sck)
      else $error("serial clock not low while deselected");
   a_lead_quiet: assert property (disable iff (!rst_n) $fell(ncs) |-> !sck [*8])
      else $error("serial clock moved too soon after select");
   a_sck_high: assert property (disable iff (!rst_n) $rose(sck) |-> sck [*4] ##1 !sck)
      else $error("serial clock high phase not four cycles");
   a_sdi_held: assert property (disable iff (!rst_n) $fell(sck) |-> $stable(sdi))
      else $error("input data moved at capture edge");
   a_sdo_held: assert property (disable iff (!rst_n)
      sdo_oe && $fell(sck) |-> $stable(sdo) ##1 $stable(sdo))
      else $error("output data moved at capture edge");
   a_select_filter: assert property (disable iff (!rst_n)
      $fell(ncs) |-> !sdo_oe ##1 !sdo_oe ##[1:4] sdo_oe)
      else $error("select filter latency wrong");
   a_release_oe: assert property (disable iff (!rst_n) $rose(ncs) |-> ##[1:5] !sdo_oe)
      else $error("output not released after deselect");
   a_gap_time: assert property (disable iff (!rst_n) $fell(ncs) |-> hi_cnt >= 5'h10)
      else $error("select high time too short");
   a_frame_bits: assert property (disable iff (!rst_n) $rose(ncs) |-> bit_cnt == 7'h20)
      else $error("frame not thirty-two clocks");
endmodule
`default_nettype wire

/* tb/spi_frame_slave_with_comm_check_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_frame_slave_with_comm_check_tb
   import sfs_pkg::*;
;
   localparam int CCL = 2000;
   localparam int CCI = 4000;
   logic        clk_sys = 1'b0;
   logic        rst_n;
   logic        dhi;
   logic        dlo;
   logic        rx_ready;
   logic [25:0] rsp_data;
   logic        req_valid;
   logic        req_ready;
   logic [3:0]  req_cmd;
   logic        req_rw;
   logic [25:0] req_data;
   logic        rsp_valid;
   logic [31:0] rsp_frame;
   logic        rsp_par_ok;
   logic        rx_valid;
   logic [30:0] rx_data;
   logic [3:0]  rx_cmd;
   logic        cc_fault;
   logic [31:0] pend;
   logic [31:0] e;
   logic [31:0] f;
   logic [31:0] g;
   logic [63:0] got;
   logic [30:0] q[$];
   logic [3:0]  c;
   logic        rw;
   logic [25:0] d;
   int          failures = 0;
   int          total_checks = 0;

   sfs_link_if lk1 ();
   sfs_link_if lk2 ();

   sfs_host sfs_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk1),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_rw(req_rw),
      .req_data(req_data), .rsp_valid(rsp_valid), .rsp_frame(rsp_frame),
      .rsp_par_ok(rsp_par_ok));
   sfs_dev #(.CC_LIMIT(CCL), .CC_INIT_LIMIT(CCI)) sfs_dev_inst (.clk_sys(clk_sys),
      .rst_n(rst_n), .link(lk1), .disable_pin_active_high(dhi),
      .disable_pin_active_low(dlo), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_cmd(rx_cmd), .rsp_data(rsp_data), .cc_fault(cc_fault));
   // Second device faces the bench driver; disables held so its timer stays still
   sfs_dev #(.CC_LIMIT(CCL), .CC_INIT_LIMIT(CCI)) sfs_dev_b_inst (.clk_sys(clk_sys),
      .rst_n(rst_n), .link(lk2), .disable_pin_active_high(1'b1),
      .disable_pin_active_low(1'b0), .rx_valid(), .rx_ready(1'b1), .rx_data(),
      .rx_cmd(), .rsp_data(rsp_data), .cc_fault());
   sfs_link_properties sfs_link_properties_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .ncs(lk1.ncs), .sck(lk1.sck), .sdi(lk1.sdi), .sdo(lk1.sdo), .sdo_oe(lk1.sdo_oe));

   always #12.5 clk_sys = ~clk_sys;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input string w, input logic [31:0] x, input logic [31:0] y);
      total_checks++;
      if (y !== x)
      begin
         $display("ERROR %s expected %h seen %h", w, x, y);
         failures++;
      end
   endtask

   function automatic logic [31:0] mkf(input logic [30:0] p);
      return {p, ~(^p)};
   endfunction

   function automatic logic [31:0] rp(input logic [31:0] fr);
      return mkf({fr[31:27], rsp_data[25:1], 1'b0});
   endfunction

   task automatic hx(input logic [3:0] cm, input logic r, input logic [25:0] dt);
      req_cmd = cm;
      req_rw = r;
      req_data = dt;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) tick(1);
      tick(1);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1) tick(1);
   endtask

   // Bit-bangs up to 64 clocks; blip gives a one-cycle select glitch at that bit
   task automatic rog(input logic [63:0] v, input int n, input int blip);
      lk2.ncs = 1'b0;
      got = 64'h0;
      tick(24);
      for (int i = n - 1; i >= 0; i--)
      begin
         lk2.sdi = v[i];
         lk2.sck = 1'b1;
         tick(4);
         got = {got[62:0], lk2.sdo_oe & lk2.sdo};
         lk2.sck = 1'b0;
         if (i == blip)
         begin
            lk2.ncs = 1'b1;
            tick(1);
            lk2.ncs = 1'b0;
            tick(3);
         end
         else
            tick(4);
      end
      tick(4);
      lk2.ncs = 1'b1;
      lk2.sdi = ~lk2.sdi;
      tick(16);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      $display("ERROR watchdog expected done seen timeout");
      conclude();
   end

   initial
   begin
      rst_n = 1'b0;
      {dhi, rx_ready, req_valid, req_cmd, req_rw, req_data, rsp_data} = '0;
      dlo = 1'b1;
      lk2.ncs = 1'b1;
      lk2.sck = 1'b0;
      lk2.sdi = 1'b0;
      tick(8);
      rst_n = 1'b1;
      pend = 32'h0;
      // Receive queue stalls, so late frames find it full and are refused
      for (int i = 0; i < 40; i++)
      begin
         c = 4'(i);
         rw = i[0];
         d = 26'(i * 32'h0123457);
         rsp_data = ~d;
         hx(c, rw, d);
         chk("reply", pend, rsp_frame);
         chk("par_ok", 32'(^pend), 32'(rsp_par_ok));
         if (c <= LAST_CMD && q.size() < FIFO_DEPTH)
         begin
            q.push_back({c, rw, d});
            pend = mkf({c, rw, rsp_data[25:1], 1'b0});
            chk("rx_cmd", 32'(c), 32'(rx_cmd));
         end
         else
            pend = 32'h0;
      end
      $display("test commands done");
      rx_ready = 1'b1;
      while (q.size() > 0)
      begin
         chk("rx_valid", 32'h1, 32'(rx_valid));
         chk("rx_data", 32'(q.pop_front()), 32'(rx_data));
         tick(1);
      end
      rx_ready = 1'b0;
      chk("rx_empty", 32'h0, 32'(rx_valid));
      $display("test drain done");
      hx(4'h1, 1'b0, 26'h155);
      chk("reply", pend, rsp_frame);
      pend = mkf({4'h1, 1'b0, rsp_data[25:1], 1'b0});
      tick(CCL - 100);
      chk("cc_fault", 32'h0, 32'(cc_fault));
      tick(200);
      chk("cc_fault", 32'h1, 32'(cc_fault));
      hx(4'h2, 1'b1, 26'h3);
      chk("reply", pend, rsp_frame);
      chk("cc_fault", 32'h0, 32'(cc_fault));
      pend = mkf({4'h2, 1'b1, rsp_data[25:1], 1'b1});
      hx(4'h3, 1'b1, 26'h5);
      chk("fault_bit", pend, rsp_frame);
      rst_n = 1'b0;
      tick(8);
      chk("oe_reset", 32'h0, 32'(lk1.sdo_oe));
      rst_n = 1'b1;
      tick(CCI - 100);
      chk("cc_init", 32'h0, 32'(cc_fault));
      tick(200);
      chk("cc_init", 32'h1, 32'(cc_fault));
      hx(4'h3, 1'b0, 26'h7);
      chk("reply", 32'h0, rsp_frame);
      $display("test timer done");
      f = mkf({4'h3, 1'b0, 26'h1234567});
      rog(64'(f), 32, -1);
      chk("first", 32'h0, got[31:0]);
      rog(64'(f ^ 32'h1), 32, -1);
      chk("after_good", rp(f), got[31:0]);
      g = mkf({4'h5, 1'b1, 26'h2aaaaaa});
      rog(64'(g), 32, -1);
      chk("after_parity", 32'h0, got[31:0]);
      rog({31'h0, 1'b1, g}, 33, -1);
      e = mkf({4'h7, 1'b0, 26'h0c3c3c3});
      rog(64'(e), 32, -1);
      chk("after_count", 32'h0, got[31:0]);
      rog(64'h0, 0, -1);
      g = mkf({4'he, 1'b0, 26'h0f0f0f0});
      rog(64'(g), 32, -1);
      chk("after_empty", rp(e), got[31:0]);
      e = mkf({4'h9, 1'b1, 26'h3});
      rog(64'(e), 32, -1);
      chk("after_bad_cmd", 32'h0, got[31:0]);
      g = mkf({4'h2, 1'b0, 26'h1555555});
      rog(64'(g), 32, 16);
      chk("after_glitch", rp(e), got[31:0]);
      e = mkf({4'h4, 1'b1, 26'h00ff00f});
      f = mkf({4'h6, 1'b0, 26'h3f00ff0});
      rog({e, f}, 64, -1);
      chk("chain_reply", rp(g), got[63:32]);
      chk("chain_fwd", e, got[31:0]);
      rog(64'(g), 32, -1);
      chk("after_chain", rp(f), got[31:0]);
      $display("test misuse done");
      conclude();
   end
endmodule
`default_nettype wire
